// ==== logic/host_port_pkg.sv ====
// shared constants and carriers for the host parallel port
package host_port_pkg;
   localparam int DATA_W = 16;
   localparam int MEM_AW = 16;
   // register select codes
   localparam logic [1:0] SEL_MEMORY_DATA_WINDOW = 2'h0;
   localparam logic [1:0] SEL_MESSAGE_BOX = 2'h1;
   localparam logic [1:0] SEL_MEMORY_ADDRESS_POINTER = 2'h2;
   localparam logic [1:0] SEL_PORT_STATUS = 2'h3;
   // reset values
   localparam logic [15:0] RST_POINTER = 16'h0000;
   localparam logic [15:0] RST_BOX = 16'h0000;
   // status bit positions
   localparam int ST_OUT_FULL = 0;
   localparam int ST_IN_FULL = 1;
   localparam int ST_MEM_BUSY = 2;
   // pointer step after each data access
   localparam logic [15:0] PTR_STEP = 16'h0001;

   // one memory request toward the internal memory
   typedef struct packed
   {
      logic write;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mem_req_t;
endpackage

// ==== logic/two_entry_buffer.sv ====
// two-entry valid/ready buffer for memory requests
`timescale 1ns/1ns
module two_entry_buffer
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire host_port_pkg::mem_req_t in_data,
   output logic out_valid,
   input wire logic out_ready,
   output host_port_pkg::mem_req_t out_data
);
   host_port_pkg::mem_req_t slot [2];
   host_port_pkg::mem_req_t next_slot [2];
   logic [1:0] count;
   logic [1:0] next_count;

   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = slot[0];

   // slot 0 is always the head; a pop shifts slot 1 down
   always_comb
   begin
      logic push;
      logic pop;
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_slot[0] = slot[0];
      next_slot[1] = slot[1];
      next_count = count;
      if (pop)
      begin
         next_slot[0] = slot[1];
      end
      if (push)
      begin
         if (count == 2'h0 || (count == 2'h1 && pop))
         begin
            next_slot[0] = in_data;
         end
         else
         begin
            next_slot[1] = in_data;
         end
      end
      next_count = count + 2'(push) - 2'(pop);
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         slot[0] <= '0;
         slot[1] <= '0;
         count <= 2'h0;
      end
      else
      begin
         slot[0] <= next_slot[0];
         slot[1] <= next_slot[1];
         count <= next_count;
      end
   end
endmodule

// ==== logic/host_parallel_port.sv ====
// host parallel port: strobe capture, port registers and memory access path
`timescale 1ns/1ns
module host_parallel_port
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic port_select_n,
   input wire logic host_read_strobe_n,
   input wire logic host_write_strobe_n,
   input wire logic register_select_hi,
   input wire logic register_select_lo,
   input wire logic [15:0] host_data_in,
   output logic [15:0] host_data_out,
   output logic host_data_oe,
   output logic outgoing_box_irq,
   output logic mem_req_valid,
   input wire logic mem_req_ready,
   output host_port_pkg::mem_req_t mem_req,
   input wire logic mem_rvalid,
   input wire logic [15:0] mem_rdata,
   input wire logic fw_box_write,
   input wire logic [15:0] fw_box_wdata,
   input wire logic fw_box_read,
   output logic [15:0] inbound_box,
   output logic inbound_box_full
);
   // three-stage synchronisers for the port select and strobe inputs; select lines and data are sampled directly
   logic [2:0] cs_sync, rd_sync, wr_sync;
   logic [2:0] next_cs_sync, next_rd_sync, next_wr_sync;
   logic cs_n, rd_n, wr_n;
   logic next_cs_n, next_rd_n, next_wr_n;
   logic [1:0] sel_q, next_sel_q;
   logic [15:0] din_q, next_din_q;
   logic [15:0] pointer, next_pointer;
   logic [15:0] out_box, next_out_box;
   logic out_full, next_out_full;
   logic [15:0] in_box, next_in_box;
   logic in_full, next_in_full;
   logic [15:0] read_latch, next_read_latch;
   logic [15:0] dout, next_dout;
   logic rd_rise, wr_rise, rd_fall;
   logic buf_in_ready, buf_in_valid;
   host_port_pkg::mem_req_t buf_in_data;
   logic [15:0] status_word;

   // a level counts once stages two and three agree
   always_comb
   begin
      next_cs_sync = {cs_sync[1:0], port_select_n};
      next_rd_sync = {rd_sync[1:0], host_read_strobe_n};
      next_wr_sync = {wr_sync[1:0], host_write_strobe_n};
      next_cs_n = (cs_sync[2] == cs_sync[1]) ? cs_sync[2] : cs_n;
      next_rd_n = (rd_sync[2] == rd_sync[1]) ? rd_sync[2] : rd_n;
      next_wr_n = (wr_sync[2] == wr_sync[1]) ? wr_sync[2] : wr_n;
   end

   // rising edge of a strobe while selected takes the access
   assign rd_rise = next_rd_n && !rd_n && !cs_n;
   assign wr_rise = next_wr_n && !wr_n && !cs_n;
   assign rd_fall = !next_rd_n && rd_n && !next_cs_n;

   // pointer after one data access; the same step serves prefetch and advance
   function automatic logic [15:0] step_pointer(input logic [15:0] p);
      return p + host_port_pkg::PTR_STEP;
   endfunction

   // status bits at their named positions; upper bits read as zero
   always_comb
   begin
      status_word = 16'h0000;
      status_word[host_port_pkg::ST_OUT_FULL] = out_full;
      status_word[host_port_pkg::ST_IN_FULL] = in_full;
      status_word[host_port_pkg::ST_MEM_BUSY] = !buf_in_ready;
   end

   // a data write enters the buffer; a full buffer drops it and shows busy
   always_comb
   begin
      buf_in_valid = 1'b0;
      buf_in_data = '0;
      if (wr_rise && sel_q == host_port_pkg::SEL_MEMORY_DATA_WINDOW)
      begin
         buf_in_valid = 1'b1;
         buf_in_data.write = 1'b1;
         buf_in_data.addr = pointer;
         buf_in_data.wdata = din_q;
      end
      else if (wr_rise && sel_q == host_port_pkg::SEL_MEMORY_ADDRESS_POINTER)
      begin
         // a new pointer fetches its own word; dropped if the buffer is full
         buf_in_valid = 1'b1;
         buf_in_data.write = 1'b0;
         buf_in_data.addr = din_q;
         buf_in_data.wdata = 16'h0000;
      end
      else if (rd_rise && sel_q == host_port_pkg::SEL_MEMORY_DATA_WINDOW)
      begin
         // prefetch the next word so the following read finds it ready
         buf_in_valid = 1'b1;
         buf_in_data.write = 1'b0;
         buf_in_data.addr = step_pointer(pointer);
         buf_in_data.wdata = 16'h0000;
      end
   end

   // port register state
   always_comb
   begin
      next_sel_q = sel_q;
      next_din_q = din_q;
      next_pointer = pointer;
      next_out_box = out_box;
      next_out_full = out_full;
      next_in_box = in_box;
      next_in_full = in_full;
      next_read_latch = read_latch;
      next_dout = dout;
      // the host keeps address and data stable until the strobe rises
      if (!rd_n || !wr_n)
      begin
         next_sel_q = {register_select_hi, register_select_lo};
         next_din_q = host_data_in;
      end
      if (mem_rvalid)
      begin
         next_read_latch = mem_rdata;
      end
      if (fw_box_read)
      begin
         next_in_full = 1'b0;
      end
      if (fw_box_write)
      begin
         next_out_box = fw_box_wdata;
         next_out_full = 1'b1;
      end
      // drive read data at strobe start, chosen by the live select lines
      if (rd_fall)
      begin
         case ({register_select_hi, register_select_lo})
            host_port_pkg::SEL_MEMORY_DATA_WINDOW: next_dout = read_latch;
            host_port_pkg::SEL_MESSAGE_BOX: next_dout = out_box;
            host_port_pkg::SEL_MEMORY_ADDRESS_POINTER: next_dout = pointer;
            host_port_pkg::SEL_PORT_STATUS: next_dout = status_word;
            default: next_dout = 16'h0000;
         endcase
      end
      if (wr_rise)
      begin
         case (sel_q)
            host_port_pkg::SEL_MEMORY_DATA_WINDOW:
            begin
               if (buf_in_ready)
               begin
                  next_pointer = step_pointer(pointer);
               end
            end
            host_port_pkg::SEL_MESSAGE_BOX:
            begin
               next_in_box = din_q;
               next_in_full = 1'b1; // set wins over firmware clear
            end
            host_port_pkg::SEL_MEMORY_ADDRESS_POINTER:
            begin
               // new pointer: its word is fetched by the request path above
               next_pointer = din_q;
            end
            default: next_pointer = pointer; // status is read-only
         endcase
      end
      if (rd_rise)
      begin
         case (sel_q)
            host_port_pkg::SEL_MEMORY_DATA_WINDOW:
            begin
               if (buf_in_ready)
               begin
                  next_pointer = step_pointer(pointer);
               end
            end
            host_port_pkg::SEL_MESSAGE_BOX:
            begin
               // host read of the box retires the outgoing message
               if (!fw_box_write)
               begin
                  next_out_full = 1'b0;
               end
            end
            default: ; // pointer and status reads change no state
         endcase
      end
   end

   always_ff @(posedge mclk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cs_sync <= 3'h7;
         rd_sync <= 3'h7;
         wr_sync <= 3'h7;
         cs_n <= 1'b1;
         rd_n <= 1'b1;
         wr_n <= 1'b1;
         sel_q <= 2'h0;
         din_q <= 16'h0000;
         pointer <= host_port_pkg::RST_POINTER;
         out_box <= host_port_pkg::RST_BOX;
         out_full <= 1'b0;
         in_box <= host_port_pkg::RST_BOX;
         in_full <= 1'b0;
         read_latch <= 16'h0000;
         dout <= 16'h0000;
      end
      else
      begin
         cs_sync <= next_cs_sync;
         rd_sync <= next_rd_sync;
         wr_sync <= next_wr_sync;
         cs_n <= next_cs_n;
         rd_n <= next_rd_n;
         wr_n <= next_wr_n;
         sel_q <= next_sel_q;
         din_q <= next_din_q;
         pointer <= next_pointer;
         out_box <= next_out_box;
         out_full <= next_out_full;
         in_box <= next_in_box;
         in_full <= next_in_full;
         read_latch <= next_read_latch;
         dout <= next_dout;
      end
   end

   // the memory side may stall; a full buffer drops the memory request of the host's access
   two_entry_buffer u_req_buffer
   (
      .mclk(mclk),
      .arst_n(arst_n),
      .in_valid(buf_in_valid),
      .in_ready(buf_in_ready),
      .in_data(buf_in_data),
      .out_valid(mem_req_valid),
      .out_ready(mem_req_ready),
      .out_data(mem_req)
   );

   // bus driven only while selected and reading
   assign host_data_out = dout;
   assign host_data_oe = !rd_n && !cs_n;
   assign outgoing_box_irq = out_full;
   assign inbound_box = in_box;
   assign inbound_box_full = in_full;
endmodule

// ==== tb/host_port_monitor.sv ====
// checker for strobes, irq, inbound box and memory request handshake
`timescale 1ns/1ns
module host_port_monitor
(
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic port_select_n,
   input wire logic host_read_strobe_n,
   input wire logic host_data_oe,
   input wire logic outgoing_box_irq,
   input wire logic mem_req_valid,
   input wire logic mem_req_ready,
   input wire host_port_pkg::mem_req_t mem_req,
   input wire logic fw_box_write,
   input wire logic fw_box_read,
   input wire logic inbound_box_full
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);

   // the bus is driven only after a read strobe passes the synchronizer
   AST_OE_CAUSE: assert property (host_data_oe |-> !$past(host_read_strobe_n, 3) || !$past(host_read_strobe_n, 4))
      else $error("bus driven without read strobe");
   AST_OE_IDLE: assert property (host_read_strobe_n [*6] |-> !host_data_oe)
      else $error("bus driven while idle");
   AST_OE_DESELECT: assert property (port_select_n [*6] |-> !host_data_oe)
      else $error("bus driven while deselected");
   AST_IRQ_SET: assert property (fw_box_write |=> outgoing_box_irq)
      else $error("irq missing after box load");
   // a drop of the irq needs a host read a few cycles back
   AST_IRQ_FALL: assert property ($fell(outgoing_box_irq) |-> !$past(host_read_strobe_n, 4)
      || !$past(host_read_strobe_n, 5) || !$past(host_read_strobe_n, 6))
      else $error("irq dropped without read");
   AST_IRQ_HOLD: assert property ((host_read_strobe_n [*8] ##0 outgoing_box_irq) |=> outgoing_box_irq)
      else $error("irq lost while host idle");
   AST_REQ_HOLD: assert property (mem_req_valid && !mem_req_ready |=> mem_req_valid && $stable(mem_req))
      else $error("request changed while stalled");
   AST_IN_HOLD: assert property (inbound_box_full && !fw_box_read |=> inbound_box_full)
      else $error("inbound flag lost");
endmodule

bind host_parallel_port host_port_monitor mon (.mclk, .arst_n, .port_select_n, .host_read_strobe_n,
   .host_data_oe, .outgoing_box_irq, .mem_req_valid, .mem_req_ready, .mem_req, .fw_box_write,
   .fw_box_read, .inbound_box_full);

// ==== tb/host_bus_model.sv ====
// host processor model driving the parallel port pins
`timescale 1ns/1ns
module host_bus_model
(
   input wire logic mclk,
   output logic port_select_n,
   output logic host_read_strobe_n,
   output logic host_write_strobe_n,
   output logic register_select_hi,
   output logic register_select_lo,
   output logic [15:0] host_data_in,
   input wire logic [15:0] host_data_out
);
   // idle pins at time zero
   initial
   begin
      port_select_n = 1'b1;
      host_read_strobe_n = 1'b1;
      host_write_strobe_n = 1'b1;
      {register_select_hi, register_select_lo} = 2'h3;
      host_data_in = 16'h0000;
   end

   // one access; select and lines outlive the strobe since the port syncs it late
   task automatic access(input logic wr, input logic [1:0] sel, input logic [15:0] wd, input int low,
      output logic [15:0] rd);
      @(negedge mclk);
      port_select_n = 1'b0;
      {register_select_hi, register_select_lo} = sel;
      host_data_in = wd;
      @(negedge mclk);
      host_write_strobe_n = !wr;
      host_read_strobe_n = wr;
      repeat (low) @(negedge mclk);
      rd = host_data_out;
      host_write_strobe_n = 1'b1;
      host_read_strobe_n = 1'b1;
      repeat (6) @(negedge mclk);
      port_select_n = 1'b1;
      host_data_in = ~wd; // released bus never shows the last word
      repeat (6) @(negedge mclk);
   endtask
endmodule

// ==== tb/testbench.sv ====
// self-checking bench for the host parallel port
`timescale 1ns/1ns
module testbench;
   typedef struct packed
   {
      logic wr;
      logic [1:0] sel;
      logic [15:0] wd;
      logic chk;
      logic [15:0] exp;
   } row_t;
   logic mclk, arst_n, cs_n, rd_n, wr_n, sel_hi, sel_lo, oe, irq, req_valid, stall, rvalid, fw_wr, fw_rd, in_full;
   logic [15:0] din, dout, rdata, in_box, fw_data, got;
   host_port_pkg::mem_req_t req;
   logic [15:0] mem [256];
   int num_errors = 0;
   int cmp_count = 0;
   int n;
   row_t rows [9] = '{'{1'b1, 2'h2, 16'h0010, 1'b0, 16'h0000}, '{1'b1, 2'h0, 16'hA5A5, 1'b0, 16'h0000},
      '{1'b1, 2'h0, 16'h5A5A, 1'b0, 16'h0000}, '{1'b0, 2'h2, 16'h0000, 1'b1, 16'h0012},
      '{1'b1, 2'h1, 16'h1234, 1'b0, 16'h0000}, '{1'b0, 2'h3, 16'h0000, 1'b1, 16'h0002},
      '{1'b1, 2'h2, 16'h0010, 1'b0, 16'h0000}, '{1'b0, 2'h0, 16'h0000, 1'b1, 16'hA5A5},
      '{1'b0, 2'h0, 16'h0000, 1'b1, 16'h5A5A}};

   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   host_parallel_port uut (.mclk(mclk), .arst_n(arst_n), .port_select_n(cs_n), .host_read_strobe_n(rd_n),
      .host_write_strobe_n(wr_n), .register_select_hi(sel_hi), .register_select_lo(sel_lo),
      .host_data_in(din), .host_data_out(dout), .host_data_oe(oe), .outgoing_box_irq(irq),
      .mem_req_valid(req_valid), .mem_req_ready(!stall), .mem_req(req), .mem_rvalid(rvalid),
      .mem_rdata(rdata), .fw_box_write(fw_wr), .fw_box_wdata(fw_data), .fw_box_read(fw_rd),
      .inbound_box(in_box), .inbound_box_full(in_full));
   host_bus_model host (.mclk(mclk), .port_select_n(cs_n), .host_read_strobe_n(rd_n),
      .host_write_strobe_n(wr_n), .register_select_hi(sel_hi), .register_select_lo(sel_lo),
      .host_data_in(din), .host_data_out(dout));

   // memory: one-cycle read answer; data line scrambles between answers
   always @(posedge mclk)
   begin
      rvalid <= 1'b0;
      rdata <= ~rdata;
      if (req_valid && !stall)
      begin
         if (req.write) mem[req.addr[7:0]] <= req.wdata;
         rvalid <= !req.write;
         rdata <= mem[req.addr[7:0]];
      end
   end

   task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] seen);
      cmp_count++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic acc(input logic wr, input logic [1:0] sel, input logic [15:0] wd);
      host.access(wr, sel, wd, 6, got);
   endtask

   task automatic finish_test;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   initial
   begin
      {arst_n, stall, fw_wr, fw_rd} = 4'h0;
      fw_data = 16'h0000;
      repeat (2) @(negedge mclk);
      arst_n = 1'b1;
      foreach (rows[i])
      begin
         acc(rows[i].wr, rows[i].sel, rows[i].wd);
         if (rows[i].chk) check16("row read", rows[i].exp, got);
      end
      check16("word 16", 16'hA5A5, mem[16]);
      check16("word 17", 16'h5A5A, mem[17]);
      check16("inbound box", 16'h1234, in_box);
      $display("table done");
      // firmware retires inbound and loads outgoing in the same cycle
      @(negedge mclk);
      {fw_rd, fw_wr} = 2'h3;
      fw_data = 16'hBEEF;
      @(negedge mclk);
      {fw_rd, fw_wr} = 2'h0;
      @(negedge mclk);
      check16("inbound full", 16'h0000, {15'h0000, in_full});
      check16("irq set", 16'h0001, {15'h0000, irq});
      host.access(1'b0, 2'h3, 16'h0000, 9, got);
      check16("status", 16'h0001, got);
      acc(1'b0, 2'h1, 16'h0000);
      check16("outgoing box", 16'hBEEF, got);
      check16("irq clear", 16'h0000, {15'h0000, irq});
      $display("box test done");
      // pointer fetch completes first; then stalled memory fills the buffer and one write is refused
      acc(1'b1, 2'h2, 16'h0040);
      stall = 1'b1;
      n = 0;
      got = 16'h0000;
      while (got[2] !== 1'b1 && n < 4)
      begin
         acc(1'b1, 2'h0, 16'h0007);
         n++;
         acc(1'b0, 2'h3, 16'h0000);
      end
      check16("words held", 16'h0002, 16'(n));
      acc(1'b1, 2'h0, 16'h0009);
      stall = 1'b0;
      acc(1'b0, 2'h2, 16'h0000);
      check16("pointer", 16'h0042, got);
      check16("word 64", 16'h0007, mem[64]);
      check16("word 65", 16'h0007, mem[65]);
      $display("stall test done");
      @(negedge mclk);
      arst_n = 1'b0;
      @(negedge mclk);
      arst_n = 1'b1;
      acc(1'b0, 2'h2, 16'h0000);
      check16("reset pointer", host_port_pkg::RST_POINTER, got);
      $display("reset test done");
      finish_test;
   end
endmodule
